//--- switch_spi_slave_port.v
// switch_spi_slave_port.v: serial slave port of a multi-output switch
// assumes SCLK, SI and chip select come from pins, oversampled by CLOCK
// (200 MHz against an SCLK of at most a few MHz)
//
// Summary of operation
// RQ1: full-duplex four-line serial slave port
// RQ2: both words travel MSB first, D15 leading
// RQ3: output control bit 0 off, 1 on
// RQ4: sample SI on falling SCLK while selected
// RQ5: shift next status bit on rising SCLK
// RQ6: master holds SCLK low changing chip select
// RQ7: master keeps SCLK low while deselected
// RQ8: deselected: ignore SCLK, SI; SO high-impedance
// RQ9: chip select rise commits word to register
// RQ10: chip select fall loads status word
// RQ11: commit only when bit count multiple of 16
// RQ12: D11:D0 data, D14:D12 select, D15 watchdog
// RQ13: bit counter cleared at chip select fall
`timescale 1ns/1ps
`include "spi_port_regs.vh"

module switch_spi_slave_port
(
    // clock and reset
    input  wire        CLOCK,
    input  wire        RST,
    // serial pins
    input  wire        SCLK,
    input  wire        SI,
    input  wire        CS_N,
    output reg         SO_OUT,
    output reg         SO_OE,
    // status to report, sampled at selection
    input  wire [15:0] STATUS_WORD,
    // configuration registers
    output reg  [11:0] OUTPUT_CTRL,
    output reg  [11:0] DIRECT_IN_CTRL,
    output reg  [11:0] LOAD_FAULT_CTRL,
    output reg  [11:0] WDOG_SENSE_CTRL,
    output reg  [11:0] OPEN_LOAD_CTRL,
    output reg  [11:0] CURR_LIMIT_CTRL,
    output reg  [11:0] TEST_CTRL,
    // watchdog bit of last committed word, and its commit pulse
    output reg         WDOG_BIT,
    output reg         COMMIT_PULSE
);

    wire sclk_s;               // filtered SCLK
    wire si_s;                 // filtered SI
    wire cs_n_s;               // filtered chip select

    reg         sclk_d_r;      // previous SCLK level for edge detect
    reg         cs_n_d_r;      // previous chip select level
    reg  [15:0] rx_r;          // input shift register
    reg  [15:0] tx_r;          // output shift register
    reg  [3:0]  cnt_r;         // bits modulo 16
    reg         any_r;         // at least one bit clocked this access

    wire sel     = ~cs_n_s;
    wire sclk_f  = sclk_d_r & ~sclk_s & sel;    // falling SCLK, selected
    wire sclk_r  = ~sclk_d_r & sclk_s & sel;    // rising SCLK, selected
    wire cs_fall = cs_n_d_r & ~cs_n_s;
    wire cs_rise = ~cs_n_d_r & cs_n_s;

    // synchronisers; chip select idles high so it resets high
    pin_sync #(.INIT(1'b0)) u_sclk
    (
        .clk  (CLOCK),
        .rst  (RST),
        .din  (SCLK),
        .dout (sclk_s)
    );

    pin_sync #(.INIT(1'b0)) u_si
    (
        .clk  (CLOCK),
        .rst  (RST),
        .din  (SI),
        .dout (si_s)
    );

    pin_sync #(.INIT(1'b1)) u_cs
    (
        .clk  (CLOCK),
        .rst  (RST),
        .din  (CS_N),
        .dout (cs_n_s)
    );

    // edge history of the filtered pins
    always @(posedge CLOCK)
    begin
        if (RST)
        begin
            sclk_d_r <= 1'b0;
            cs_n_d_r <= 1'b1;
        end
        else
        begin
            sclk_d_r <= sclk_s;
            cs_n_d_r <= cs_n_s;
        end
    end

    // receive side: shift in and count bits
    // edges outside selection never reach here, so a stray SCLK while
    // deselected is harmless even if the master breaks its idle habit
    always @(posedge CLOCK)
    begin
        if (RST)
        begin
            rx_r  <= `STATUS_RESET;
            cnt_r <= 4'h0;
            any_r <= 1'b0;
        end
        else if (cs_fall)
        begin
            cnt_r <= 4'h0;                       // RQ13
            any_r <= 1'b0;                       // RQ13
        end
        else if (sclk_f)
        begin
            rx_r  <= {rx_r[14:0], si_s};         // RQ4 RQ2
            cnt_r <= cnt_r + 4'h1;
            any_r <= 1'b1;
        end
    end

    // transmit side: MSB sits on SO first, advances on rising SCLK
    // the first rising edge after the leading bit moves to D14; the
    // master samples on falling edges, so D15 is read before it moves
    // the bit taken at the last falling edge enters at the bottom, so
    // after the status word SO repeats the received bits in order and
    // a daisy chain sees the first word it sent, D15 leading
    always @(posedge CLOCK)
    begin
        if (RST)
            tx_r <= `STATUS_RESET;
        else if (cs_fall)
            tx_r <= STATUS_WORD;                 // RQ10
        else if (sclk_r && any_r)
            tx_r <= {tx_r[14:0], rx_r[0]};       // RQ5 RQ2
    end

    // pin drive; SO released whenever chip select is high
    always @(posedge CLOCK)
    begin
        if (RST)
        begin
            SO_OUT <= 1'b0;
            SO_OE  <= 1'b0;
        end
        else
        begin
            SO_OE  <= sel;                       // RQ8 RQ1
            SO_OUT <= sel ? tx_r[15] : 1'b0;     // RQ1
        end
    end

    // commit at chip select rise when length is a nonzero whole word multiple
    // the commit uses the last 16 bits, so a daisy chain passes through
    always @(posedge CLOCK)
    begin
        if (RST)
        begin
            OUTPUT_CTRL     <= `CFG_RESET;
            DIRECT_IN_CTRL  <= `CFG_RESET;
            LOAD_FAULT_CTRL <= `CFG_RESET;
            WDOG_SENSE_CTRL <= `CFG_RESET;
            OPEN_LOAD_CTRL  <= `CFG_RESET;
            CURR_LIMIT_CTRL <= `CFG_RESET;
            TEST_CTRL       <= `CFG_RESET;
            WDOG_BIT        <= 1'b0;
            COMMIT_PULSE    <= 1'b0;
        end
        else
        begin
            COMMIT_PULSE <= 1'b0;
            if (cs_rise && any_r && cnt_r == 4'h0)    // RQ11 RQ9
            begin
                COMMIT_PULSE <= 1'b1;
                WDOG_BIT     <= rx_r[`WD_BIT];         // RQ12
                case (rx_r[`ADDR_HI:`ADDR_LO])         // RQ12
                `SEL_OUTPUT_CTRL:
                    OUTPUT_CTRL <= rx_r[`DATA_HI:`DATA_LO]; // RQ3
                `SEL_DIRECT_IN:
                    DIRECT_IN_CTRL <= rx_r[`DATA_HI:`DATA_LO];
                `SEL_LOAD_FAULT:
                    LOAD_FAULT_CTRL <= rx_r[`DATA_HI:`DATA_LO];
                `SEL_WDOG_SENSE:
                    WDOG_SENSE_CTRL <= rx_r[`DATA_HI:`DATA_LO];
                `SEL_OPEN_LOAD:
                    OPEN_LOAD_CTRL <= rx_r[`DATA_HI:`DATA_LO];
                `SEL_CURR_LIMIT:
                    CURR_LIMIT_CTRL <= rx_r[`DATA_HI:`DATA_LO];
                `SEL_TEST:
                    TEST_CTRL <= rx_r[`DATA_HI:`DATA_LO];
                default:
                    ;                            // unused select: no store
                endcase
            end
        end
    end

endmodule

//--- spi_port_regs.vh
// spi_port_regs.vh: constants for the switch serial slave port
// assumes inclusion by the port modules only; definitions only
`ifndef SPI_PORT_REGS_VH
`define SPI_PORT_REGS_VH

// word layout
`define WORD_BITS      16
`define WD_BIT         15
`define ADDR_HI        14
`define ADDR_LO        12
`define DATA_HI        11
`define DATA_LO        0

// target register select codes (bits 14:12)
`define SEL_OUTPUT_CTRL 3'h0
`define SEL_DIRECT_IN   3'h4
`define SEL_LOAD_FAULT  3'h2
`define SEL_WDOG_SENSE  3'h6
`define SEL_OPEN_LOAD   3'h1
`define SEL_CURR_LIMIT  3'h5
`define SEL_UNUSED      3'h3
`define SEL_TEST        3'h7

// reset values
`define CFG_RESET      12'h000
`define STATUS_RESET   16'h0000

`endif

//--- pin_sync.v
// pin_sync.v: three-flop synchroniser with agreement filter
// assumes the input is asynchronous to CLOCK; one instance per pin
`timescale 1ns/1ps
`include "spi_port_regs.vh"

module pin_sync
#(
    parameter INIT = 1'b0      // level held during reset
)
(
    input  wire clk,           // system clock
    input  wire rst,           // synchronous reset, active high
    input  wire din,           // asynchronous pin level
    output reg  dout           // filtered level
);

    reg s1_r;                  // metastability catcher, read by s2 only
    reg s2_r;                  // second stage
    reg s3_r;                  // third stage

    // shift chain; change taken only once stages two and three agree
    always @(posedge clk)
    begin
        if (rst)
        begin
            s1_r <= INIT;
            s2_r <= INIT;
            s3_r <= INIT;
            dout <= INIT;
        end
        else
        begin
            s1_r <= din;
            s2_r <= s1_r;
            s3_r <= s2_r;
            if (s2_r == s3_r)
                dout <= s3_r;  // agreement filters single-cycle glitches
        end
    end

endmodule

//--- spi_port_chk_sva.sv
// checker of the serial slave port: select, shift and commit timing
// assumes binding to the top module ports
`timescale 1ns/1ps
module spi_port_chk
(
    // clock and pins
    input wire        CLOCK,
    input wire        RST,
    input wire        SCLK,
    input wire        CS_N,
    input wire        SO_OUT,
    input wire        SO_OE,
    // results
    input wire [11:0] OUTPUT_CTRL,
    input wire        WDOG_BIT,
    input wire        COMMIT_PULSE
);
    default clocking @(posedge CLOCK); endclocking
    default disable iff (RST);
    a_so_float: assert property ($rose(CS_N) |-> ##[1:8] !SO_OE)
        else $error("so driven");
    a_so_drive: assert property ($fell(CS_N) |-> ##[1:8] SO_OE)
        else $error("so idle");
    a_so_zero: assert property (!SO_OE |-> !SO_OUT)
        else $error("so not low");
    a_so_hold: assert property ((SO_OE && !SCLK)[*8] |=>
        $stable(SO_OUT) || !SO_OE) else $error("so moved");
    a_pulse_one: assert property (COMMIT_PULSE |=> !COMMIT_PULSE)
        else $error("long pulse");
    a_commit_desel: assert property (COMMIT_PULSE |-> $past(CS_N, 3))
        else $error("early commit");
    a_reg_cause: assert property ($changed(OUTPUT_CTRL) |->
        COMMIT_PULSE || $past(COMMIT_PULSE)) else $error("reg");
    a_wd_cause: assert property ($changed(WDOG_BIT) |->
        COMMIT_PULSE || $past(COMMIT_PULSE)) else $error("wd");
endmodule
bind switch_spi_slave_port spi_port_chk spi_port_chk_inst (.CLOCK(CLOCK),
    .RST(RST), .SCLK(SCLK), .CS_N(CS_N), .SO_OUT(SO_OUT), .SO_OE(SO_OE),
    .OUTPUT_CTRL(OUTPUT_CTRL), .WDOG_BIT(WDOG_BIT),
    .COMMIT_PULSE(COMMIT_PULSE));

//--- spi_master_model.sv
// master model: drives select, serial clock and data in, reads SO
// assumes changes at falling CLOCK; each serial phase is 8 cycles
`timescale 1ns/1ps
module spi_master_model
(
    // system side
    input  wire clk,
    input  wire so_out,
    input  wire so_oe,
    // serial pins
    output reg  sclk,
    output reg  si,
    output reg  cs_n
);
    initial {sclk, si, cs_n} = 3'b001; // clock low while idle
    // one access of n bits, MSB first; rx gathers SO before each fall
    task xfer(input int n, input logic [31:0] tx, output logic [31:0] rx);
        rx = '0;
        @(negedge clk) cs_n = 0; // clock low at select
        repeat (8) @(negedge clk);
        for (int i = n - 1; i >= 0; i--)
        begin
            sclk = 1;
            si = tx[i];
            repeat (8) @(negedge clk);
            rx = {rx[30:0], so_oe ? so_out : 1'bx};
            sclk = 0;
            repeat (8) @(negedge clk);
        end
        si = 0; // data in falls to its pulldown level
        cs_n = 1;
        repeat (16) @(negedge clk);
    endtask
endmodule

//--- test_switch_spi_slave_port.sv
// testbench of the switch serial slave port
// assumes the master model owns the serial pins
`timescale 1ns/1ps
module test_switch_spi_slave_port;
    reg          CLOCK = 0;
    reg          RST = 1;
    reg   [15:0] STATUS_WORD = 16'h0000;
    wire         SCLK, SI, CS_N, SO_OUT, SO_OE, WDOG_BIT, COMMIT_PULSE;
    wire  [11:0] r [0:7];      // registers by select code
    int          n_mismatch = 0, comparisons = 0, cycles = 0;
    logic [31:0] seed = 32'h0000_f4f5, rx;
    logic [15:0] exp;
    logic [15:0] notes [$];    // words expected to commit
    switch_spi_slave_port switch_spi_slave_port_inst (.CLOCK(CLOCK),
        .RST(RST), .SCLK(SCLK), .SI(SI), .CS_N(CS_N), .SO_OUT(SO_OUT),
        .SO_OE(SO_OE), .STATUS_WORD(STATUS_WORD), .OUTPUT_CTRL(r[0]),
        .DIRECT_IN_CTRL(r[4]), .LOAD_FAULT_CTRL(r[2]),
        .WDOG_SENSE_CTRL(r[6]), .OPEN_LOAD_CTRL(r[1]),
        .CURR_LIMIT_CTRL(r[5]), .TEST_CTRL(r[7]), .WDOG_BIT(WDOG_BIT),
        .COMMIT_PULSE(COMMIT_PULSE));
    assign r[3] = 12'h000;     // unused select code stores nothing
    spi_master_model spi_master_model_inst (.clk(CLOCK), .so_out(SO_OUT),
        .so_oe(SO_OE), .sclk(SCLK), .si(SI), .cs_n(CS_N));
    initial forever #2.5 CLOCK = ~CLOCK;
    function logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction
    task check(input logic [31:0] got, input logic [31:0] want);
        comparisons++;
        if (got !== want)
        begin
            n_mismatch++;
            $display("Error at %0t: got %h want %h", $time, got, want);
        end
    endtask
    task end_of_test;
        $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
        if (n_mismatch == 0 && comparisons > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    // a hang counts as a mismatch
    always @(posedge CLOCK)
        if (++cycles == 20000)
        begin
            n_mismatch++;
            end_of_test;
        end
    // watcher: each commit takes the oldest note; empty queue is a fault
    // looks at the falling edge, where pulse and registers have settled
    always @(negedge CLOCK)
        if (COMMIT_PULSE === 1'b1)
        begin
            if (notes.size() == 0)
                check(1, 0);
            else
            begin
                exp = notes.pop_front();
                check(WDOG_BIT, exp[15]);
                if (exp[14:12] != 3)
                    check(r[exp[14:12]], exp[11:0]);
            end
        end
    initial
    begin
        repeat (4) @(negedge CLOCK);
        RST = 0;
        repeat (8) @(negedge CLOCK);
        // every select code, random data and status
        for (int s = 0; s < 8; s++)
        begin
            seed = lfsr(seed);
            STATUS_WORD = seed[31:16];
            notes.push_back({seed[15], 3'(s), seed[11:0]});
            spi_master_model_inst.xfer(16, {16'h0000, notes[$]}, rx);
            check(rx[15:0], STATUS_WORD);
        end
        // too short: no commit
        spi_master_model_inst.xfer(15, seed, rx);
        // selected with no bits clocked: no commit either
        spi_master_model_inst.xfer(0, seed, rx);
        // two words: last one commits, first comes back after status
        seed = lfsr(seed);
        notes.push_back(seed[15:0]);
        spi_master_model_inst.xfer(32, seed, rx);
        check(rx, {STATUS_WORD, seed[31:16]});
        check(notes.size(), 0);
        end_of_test;
    end
endmodule
